/* inc/sdcbs_params.svh */
// Timing counts and pin encodings for the SDRAM command and state control block.
// Assumes a 40 MHz clock (25 ns period); times are in picoseconds.
`ifndef SDCBS_PARAMS_SVH
`define SDCBS_PARAMS_SVH

`define SDCBS_CLK_PERIOD_PS 25000
`define SDCBS_PRECHARGE_PERIOD_PS 20000
`define SDCBS_ACTIVATE_TO_COLUMN_DELAY_PS 20000
`define SDCBS_REFRESH_CYCLE_TIME_PS 70000
`define SDCBS_MODE_LOAD_DELAY_PS 50000
`define SDCBS_SELF_REFRESH_EXIT_TIME_PS 80000
// Least times round up, never below one cycle
`define SDCBS_CYC(t) ((((t) + `SDCBS_CLK_PERIOD_PS - 1) / `SDCBS_CLK_PERIOD_PS) < 1 ? 1 : \
  (((t) + `SDCBS_CLK_PERIOD_PS - 1) / `SDCBS_CLK_PERIOD_PS))
`define SDCBS_PRECHARGE_CYC `SDCBS_CYC(`SDCBS_PRECHARGE_PERIOD_PS)
`define SDCBS_ACTIVATE_CYC `SDCBS_CYC(`SDCBS_ACTIVATE_TO_COLUMN_DELAY_PS)
`define SDCBS_REFRESH_CYC `SDCBS_CYC(`SDCBS_REFRESH_CYCLE_TIME_PS)
`define SDCBS_MODE_LOAD_CYC `SDCBS_CYC(`SDCBS_MODE_LOAD_DELAY_PS)
`define SDCBS_SELF_EXIT_CYC `SDCBS_CYC(`SDCBS_SELF_REFRESH_EXIT_TIME_PS)
`define SDCBS_NUM_BANKS 4
`define SDCBS_AP_BIT 10

`endif

/* inc/sdcbs_pkg.sv */
// Types shared by the SDRAM command and state control block.
// Assumes sdcbs_params.svh for numeric constants.
package sdcbs_pkg;

  typedef enum logic [3:0] {
    SDCBS_CMD_INHIBIT = 4'h0,
    SDCBS_CMD_NOP = 4'h1,
    SDCBS_CMD_ACTIVE = 4'h2,
    SDCBS_CMD_READ = 4'h3,
    SDCBS_CMD_WRITE = 4'h4,
    SDCBS_CMD_TERMINATE = 4'h5,
    SDCBS_CMD_PRECHARGE = 4'h6,
    SDCBS_CMD_REFRESH = 4'h7,
    SDCBS_CMD_LOAD_MODE = 4'h8
  } sdcbs_cmd_e;

  typedef enum logic [2:0] {
    SDCBS_BANK_IDLE = 3'b000,
    SDCBS_BANK_ACTIVATING = 3'b001,
    SDCBS_BANK_ROW_ACTIVE = 3'b010,
    SDCBS_BANK_READ = 3'b011,
    SDCBS_BANK_WRITE = 3'b100,
    SDCBS_BANK_READ_AP = 3'b101,
    SDCBS_BANK_WRITE_AP = 3'b110,
    SDCBS_BANK_PRECHARGING = 3'b111
  } sdcbs_bank_e;

  typedef enum logic [2:0] {
    SDCBS_DEV_ACTIVE = 3'b000,
    SDCBS_DEV_POWER_DOWN = 3'b001,
    SDCBS_DEV_SELF_REFRESH = 3'b010,
    SDCBS_DEV_SELF_EXIT = 3'b011,
    SDCBS_DEV_SUSPEND = 3'b100,
    SDCBS_DEV_REFRESHING = 3'b101,
    SDCBS_DEV_MODE_LOAD = 3'b110
  } sdcbs_dev_e;

  typedef logic [3:0] sdcbs_count_t;

endpackage

/* sim/sdcbs_ctrl_chk.sv */
// Assertions on the ports of the SDRAM command and state block.
// Assumes enable_in stays high while a checked sequence runs.
`timescale 1ns/1ps

module sdcbs_ctrl_chk
  import sdcbs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [1:0] bank_in,
  input wire logic [10:0] addr_in,
  input sdcbs_dev_e dev_state_out,
  input wire logic [11:0] bank_state_out,
  input wire logic all_idle_out,
  input wire logic cmd_ready_out,
  input wire logic burst_active_out,
  input wire logic [1:0] burst_bank_out,
  input wire logic suspend_out
);
  // ****
  // Helpers
  // ****
  logic cke_reg;
  wire [3:0] s = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  wire [2:0] b0 = bank_state_out[2:0];
  wire fall = enable_in && cke_reg && !cke_in;
  wire act = dev_state_out == SDCBS_DEV_ACTIVE;
  wire on0 = enable_in && cke_reg && cke_in && act && bank_in == 2'h0;

  // Own copy of the previous sample, so a stale one in the block shows up
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cke_reg <= 1'b0;
    end else if (enable_in) begin
      cke_reg <= cke_in;
    end
  end

  default clocking @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  act_row_a: assert property (on0 && s == 4'h3 && b0 == SDCBS_BANK_IDLE
    |=> b0 == SDCBS_BANK_ACTIVATING ##1 b0 == SDCBS_BANK_ROW_ACTIVE) else $error("activate");
  ap_idle_a: assert property (on0 && s[3:1] == 3'h2 && addr_in[10]
    && b0 == SDCBS_BANK_ROW_ACTIVE |=> b0 inside {SDCBS_BANK_READ_AP, SDCBS_BANK_WRITE_AP}
    ##1 b0 == SDCBS_BANK_IDLE) else $error("auto precharge access");
  burst_go_a: assert property (on0 && s[3:1] == 3'h2 && !addr_in[10]
    && b0 inside {SDCBS_BANK_ROW_ACTIVE, SDCBS_BANK_READ, SDCBS_BANK_WRITE}
    |=> burst_active_out && burst_bank_out == 2'h0
    && b0 == ($past(we_n_in) ? SDCBS_BANK_READ : SDCBS_BANK_WRITE)) else $error("burst start");
  burst_stop_a: assert property (on0 && s == 4'h6 && burst_bank_out == 2'h0
    && b0 inside {SDCBS_BANK_READ, SDCBS_BANK_WRITE} |=> b0 == SDCBS_BANK_ROW_ACTIVE)
    else $error("terminate");
  refresh_hold_a: assert property (on0 && s == 4'h1 && all_idle_out
    |=> dev_state_out == SDCBS_DEV_REFRESHING [*3] ##1 act) else $error("refresh time");
  pd_entry_a: assert property (fall && all_idle_out && (cs_n_in || s == 4'h7)
    |=> dev_state_out == SDCBS_DEV_POWER_DOWN) else $error("power-down entry");
  low_hold_a: assert property (enable_in && !cke_reg && !cke_in
    && dev_state_out inside {SDCBS_DEV_POWER_DOWN, SDCBS_DEV_SELF_REFRESH, SDCBS_DEV_SUSPEND}
    |=> $stable(dev_state_out) && $stable(bank_state_out)) else $error("low state moved");
  suspend_in_a: assert property (fall && act && b0 == SDCBS_BANK_READ
    |=> suspend_out && dev_state_out == SDCBS_DEV_SUSPEND) else $error("suspend entry");
endmodule

/* sim/sdcbs_host_model.sv */
// Controller stand-in: turns a requested command into SDRAM command pins.
// Assumes the bench changes requests just after a rising edge of clk_in.
`timescale 1ns/1ps

module sdcbs_host_model
  import sdcbs_pkg::*;
(
  input wire logic clk_in,
  input sdcbs_cmd_e cmd_in,
  input wire logic [1:0] bank_sel_in,
  input wire logic ap_in,
  input wire logic cke_req_in,
  output logic cke_out,
  output logic cs_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic [1:0] bank_out,
  output logic [10:0] addr_out
);
  // Request order (NOPs in busy spans, whole-device commands only when idle)
  // is kept by the bench that feeds this model
  logic tog_reg = 1'b0;
  logic [3:0] pins;

  // Lines that do not count under inhibit wander, so a decoder peeking at them is caught
  always_ff @(posedge clk_in) begin
    tog_reg <= !tog_reg;
  end

  always_comb begin
    case (cmd_in)
      SDCBS_CMD_NOP: pins = 4'h7;
      SDCBS_CMD_ACTIVE: pins = 4'h3;
      SDCBS_CMD_READ: pins = 4'h5;
      SDCBS_CMD_WRITE: pins = 4'h4;
      SDCBS_CMD_TERMINATE: pins = 4'h6;
      SDCBS_CMD_PRECHARGE: pins = 4'h2;
      SDCBS_CMD_REFRESH: pins = 4'h1;
      SDCBS_CMD_LOAD_MODE: pins = 4'h0;
      default: pins = {1'b1, {3{tog_reg}}};
    endcase
  end

  assign {cs_n_out, ras_n_out, cas_n_out, we_n_out} = pins;
  assign cke_out = cke_req_in;
  assign bank_out = pins[3] ? {2{tog_reg}} : bank_sel_in;
  assign addr_out = pins[3] ? {11{tog_reg}} : {ap_in, 10'h000};
endmodule

/* sim/sdram_cke_and_bank_command_states_test.sv */
// Bench of the SDRAM command and state block, fed through the controller model.
// Assumes the checker and the model are compiled before this file.
`timescale 1ns/1ps

module sdram_cke_and_bank_command_states_test
  import sdcbs_pkg::*;
;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  sdcbs_cmd_e cmd = SDCBS_CMD_NOP;
  logic [1:0] bsel = 2'h0;
  logic ap = 1'b0;
  logic cke = 1'b1;
  logic cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in;
  logic [1:0] bank_in;
  logic [10:0] addr_in;
  sdcbs_dev_e dev_state_out;
  logic [11:0] bank_state_out;
  logic all_idle_out, cmd_ready_out, burst_active_out, suspend_out;
  logic [1:0] burst_bank_out;
  int n_mismatch = 0;
  int num_checks = 0;

  always #12.5 clk_in = !clk_in;

  sdcbs_host_model sdcbs_host_model_inst (
    .clk_in, .cmd_in(cmd), .bank_sel_in(bsel), .ap_in(ap), .cke_req_in(cke),
    .cke_out(cke_in), .cs_n_out(cs_n_in), .ras_n_out(ras_n_in), .cas_n_out(cas_n_in),
    .we_n_out(we_n_in), .bank_out(bank_in), .addr_out(addr_in));
  sdcbs_ctrl sdcbs_ctrl_inst (
    .clk_in, .reset_in, .enable_in(1'b1), .cke_in, .cs_n_in, .ras_n_in, .cas_n_in,
    .we_n_in, .bank_in, .addr_in, .dev_state_out, .bank_state_out, .all_idle_out,
    .cmd_ready_out, .burst_active_out, .burst_bank_out, .suspend_out);

  // ****
  // Tasks
  // ****
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic cb(input string what, input logic seen, input logic exp);
    check(what, {11'h000, seen}, {11'h000, exp});
  endtask

  // Entered just after an edge; returns just after the edge that sampled the request
  task automatic go(input sdcbs_cmd_e c, input logic [1:0] b, input logic a, input logic k);
    cmd = c;
    bsel = b;
    ap = a;
    cke = k;
    @(posedge clk_in);
    #2;
  endtask

  task automatic cd(input sdcbs_dev_e e);
    check("device", {9'h000, dev_state_out}, {9'h000, e});
  endtask

  task automatic step(input sdcbs_cmd_e c, input logic a, input sdcbs_bank_e e);
    go(c, 2'h0, a, 1'b1);
    check("banks", bank_state_out, {9'h000, e});
  endtask

  task automatic t_bank;
    step(SDCBS_CMD_ACTIVE, 1'b0, SDCBS_BANK_ACTIVATING);
    step(SDCBS_CMD_NOP, 1'b0, SDCBS_BANK_ROW_ACTIVE);
    step(SDCBS_CMD_READ, 1'b0, SDCBS_BANK_READ);
    step(SDCBS_CMD_WRITE, 1'b0, SDCBS_BANK_WRITE);
    step(SDCBS_CMD_INHIBIT, 1'b0, SDCBS_BANK_WRITE);
    step(SDCBS_CMD_READ, 1'b0, SDCBS_BANK_READ);
    step(SDCBS_CMD_TERMINATE, 1'b0, SDCBS_BANK_ROW_ACTIVE);
    cb("burst", burst_active_out, 1'b0);
    step(SDCBS_CMD_WRITE, 1'b1, SDCBS_BANK_WRITE_AP);
    step(SDCBS_CMD_NOP, 1'b0, SDCBS_BANK_IDLE);
    step(SDCBS_CMD_PRECHARGE, 1'b0, SDCBS_BANK_IDLE);
    step(SDCBS_CMD_ACTIVE, 1'b0, SDCBS_BANK_ACTIVATING);
    step(SDCBS_CMD_NOP, 1'b0, SDCBS_BANK_ROW_ACTIVE);
    step(SDCBS_CMD_READ, 1'b0, SDCBS_BANK_READ);
    step(SDCBS_CMD_PRECHARGE, 1'b0, SDCBS_BANK_PRECHARGING);
    step(SDCBS_CMD_NOP, 1'b0, SDCBS_BANK_IDLE);
    step(SDCBS_CMD_ACTIVE, 1'b0, SDCBS_BANK_ACTIVATING);
    step(SDCBS_CMD_NOP, 1'b0, SDCBS_BANK_ROW_ACTIVE);
    go(SDCBS_CMD_PRECHARGE, 2'h3, 1'b0, 1'b1);
    check("banks", bank_state_out, 12'h002);
    go(SDCBS_CMD_PRECHARGE, 2'h3, 1'b1, 1'b1);
    check("banks", bank_state_out, 12'h007);
    step(SDCBS_CMD_NOP, 1'b0, SDCBS_BANK_IDLE);
    $display("test bank done");
  endtask

  task automatic t_whole(input sdcbs_cmd_e c, input int n, input sdcbs_dev_e st);
    go(c, 2'h0, 1'b0, 1'b1);
    cb("ready", cmd_ready_out, 1'b0);
    repeat (n) begin
      cd(st);
      go(SDCBS_CMD_NOP, 2'h0, 1'b0, 1'b1);
    end
    cd(SDCBS_DEV_ACTIVE);
    cb("idle", all_idle_out, 1'b1);
    $display("test device-wide done");
  endtask

  task automatic t_power;
    go(SDCBS_CMD_NOP, 2'h0, 1'b0, 1'b0);
    cd(SDCBS_DEV_POWER_DOWN);
    cb("ready", cmd_ready_out, 1'b0);
    go(SDCBS_CMD_ACTIVE, 2'h0, 1'b0, 1'b0);
    cd(SDCBS_DEV_POWER_DOWN);
    go(SDCBS_CMD_INHIBIT, 2'h0, 1'b0, 1'b1);
    cd(SDCBS_DEV_ACTIVE);
    cb("idle", all_idle_out, 1'b1);
    cb("ready", cmd_ready_out, 1'b1);
    step(SDCBS_CMD_ACTIVE, 1'b0, SDCBS_BANK_ACTIVATING);
    step(SDCBS_CMD_NOP, 1'b0, SDCBS_BANK_ROW_ACTIVE);
    step(SDCBS_CMD_READ, 1'b0, SDCBS_BANK_READ);
    go(SDCBS_CMD_NOP, 2'h0, 1'b0, 1'b0);
    check("suspend", {11'h000, suspend_out}, 12'h001);
    cb("ready", cmd_ready_out, 1'b0);
    go(SDCBS_CMD_TERMINATE, 2'h0, 1'b0, 1'b0);
    check("banks", bank_state_out, 12'h003);
    go(SDCBS_CMD_NOP, 2'h0, 1'b0, 1'b1);
    cd(SDCBS_DEV_ACTIVE);
    step(SDCBS_CMD_TERMINATE, 1'b0, SDCBS_BANK_ROW_ACTIVE);
    step(SDCBS_CMD_PRECHARGE, 1'b0, SDCBS_BANK_PRECHARGING);
    step(SDCBS_CMD_NOP, 1'b0, SDCBS_BANK_IDLE);
    $display("test power-down and suspend done");
  endtask

  task automatic t_self;
    go(SDCBS_CMD_REFRESH, 2'h0, 1'b0, 1'b0);
    cd(SDCBS_DEV_SELF_REFRESH);
    go(SDCBS_CMD_NOP, 2'h0, 1'b0, 1'b1);
    repeat (4) begin
      cd(SDCBS_DEV_SELF_EXIT);
      go(SDCBS_CMD_NOP, 2'h0, 1'b0, 1'b1);
    end
    cd(SDCBS_DEV_ACTIVE);
    cb("ready", cmd_ready_out, 1'b1);
    step(SDCBS_CMD_ACTIVE, 1'b0, SDCBS_BANK_ACTIVATING);
    $display("test self refresh done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****
  // Sequence
  // ****
  initial begin
    repeat (2) @(posedge clk_in);
    #2;
    reset_in = 1'b0;
    go(SDCBS_CMD_NOP, 2'h0, 1'b0, 1'b1);
    t_bank;
    t_whole(SDCBS_CMD_REFRESH, 3, SDCBS_DEV_REFRESHING);
    t_whole(SDCBS_CMD_LOAD_MODE, 2, SDCBS_DEV_MODE_LOAD);
    t_power;
    t_self;
    report_and_stop;
  end

  // Tests need under a hundred cycles; ten times that means a hang
  initial begin
    repeat (1000) @(posedge clk_in);
    n_mismatch++;
    report_and_stop;
  end
endmodule

bind sdcbs_ctrl sdcbs_ctrl_chk sdcbs_ctrl_chk_inst (
  .clk_in, .reset_in, .enable_in, .cke_in, .cs_n_in, .ras_n_in, .cas_n_in, .we_n_in,
  .bank_in, .addr_in, .dev_state_out, .bank_state_out, .all_idle_out, .cmd_ready_out,
  .burst_active_out, .burst_bank_out, .suspend_out);

/* src/sdcbs_ctrl.sv */
// SDRAM device command and state control: clock-enable handling and bank states.
// Assumes command pins and clock enable are synchronous to clk_in at 40 MHz.
//
// Function
// (R1) Clock-enable action uses previous and current sample
// (R2) Both samples low: hold low-power state
// (R3) Power-down entry/exit with NOP or inhibit
// (R4) Self refresh entry: idle, falling, refresh
// (R5) Enable low in burst suspends internal clock
// (R6) Power-down exit: idle at next edge
// (R7) Self refresh exit waits exit time
// (R8) Controller sends two NOPs during exit
// (R9) Suspend exit: next command at next edge
// (R10) Bank rules only with enable high twice
// (R11) Inhibit and NOP decode, operation continues
// (R12) Decode active, refresh, load mode, precharge
// (R13) Row active accepts read, write, precharge
// (R14) Read burst accepts read, write, terminate, precharge
// (R15) Write burst accepts read, write, terminate, precharge
// (R16) Burst terminate stops most recent burst
// (R17) Reads and writes accepted with either precharge form
// (R18) Controller avoids busy transient banks
// (R19) Precharge to precharging, then idle after period
// (R20) Active to activating, then row active
// (R21) Auto-precharge access ends idle after precharge
// (R22) Controller only NOPs during device-wide operations
// (R23) Refresh and mode load hold, then idle
// (R24) Refresh and mode load only when idle
// (R25) Precharge all only from valid states
// (R26) Precharge to idle bank acts as NOP
`timescale 1ns/1ps
`include "sdcbs_params.svh"

module sdcbs_ctrl
  import sdcbs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [1:0] bank_in,
  input wire logic [10:0] addr_in,
  output sdcbs_dev_e dev_state_out,
  output logic [11:0] bank_state_out,
  output logic all_idle_out,
  output logic cmd_ready_out,
  output logic burst_active_out,
  output logic [1:0] burst_bank_out,
  output logic suspend_out
);

  // ****************************************************************
  // Constants and state
  // ****************************************************************
  // Waits are whole cycles rounded up, never shorter than the stated time
  // Four counter bits cover the longest wait at this clock
  localparam sdcbs_count_t PRE_CYC = sdcbs_count_t'(`SDCBS_PRECHARGE_CYC);
  localparam sdcbs_count_t ACT_CYC = sdcbs_count_t'(`SDCBS_ACTIVATE_CYC);
  localparam sdcbs_count_t REF_CYC = sdcbs_count_t'(`SDCBS_REFRESH_CYC);
  localparam sdcbs_count_t MRD_CYC = sdcbs_count_t'(`SDCBS_MODE_LOAD_CYC);
  localparam sdcbs_count_t XSR_CYC = sdcbs_count_t'(`SDCBS_SELF_EXIT_CYC);

  typedef struct packed {
    logic cke_prev;
    sdcbs_dev_e dev;
    sdcbs_count_t dev_cnt;
    sdcbs_bank_e [3:0] bank;
    sdcbs_count_t [3:0] bank_cnt;
    logic burst_valid;
    logic [1:0] burst_bank;
    // Output copies, registered so no port sees decode glitches
    sdcbs_dev_e dev_out;
    logic [11:0] bank_out;
    logic all_idle;
    logic ready;
    logic suspend;
  } sdcbs_state_s;

  sdcbs_state_s state_reg;
  sdcbs_state_s state_next;
  sdcbs_cmd_e cmd;

  sdcbs_decode decode_inst (
    .cs_n_in(cs_n_in),
    .ras_n_in(ras_n_in),
    .cas_n_in(cas_n_in),
    .we_n_in(we_n_in),
    .cmd_out(cmd)
  );

  // ****************************************************************
  // Per-bank flags of the present state and of the command address
  // ****************************************************************
  logic [3:0] bank_idle;
  logic [3:0] bank_burst;
  logic [3:0] bank_open;
  logic [3:0] bank_plain_burst;
  logic [3:0] bank_pre_target;
  logic [3:0] bank_timer_done;

  for (genvar g = 0; g < `SDCBS_NUM_BANKS; g++) begin : bank_flag_gen
    assign bank_idle[g] = (state_reg.bank[g] == SDCBS_BANK_IDLE);
    // Auto-precharge accesses count too: power-down must not cut any burst
    assign bank_burst[g] = state_reg.bank[g] inside {SDCBS_BANK_READ, SDCBS_BANK_WRITE,
        SDCBS_BANK_READ_AP, SDCBS_BANK_WRITE_AP};
    // Only these states take a column command or a precharge
    assign bank_open[g] = state_reg.bank[g] inside {SDCBS_BANK_ROW_ACTIVE,
        SDCBS_BANK_READ, SDCBS_BANK_WRITE};
    assign bank_plain_burst[g] = state_reg.bank[g] inside {SDCBS_BANK_READ,
        SDCBS_BANK_WRITE};
    // Address bit 10 widens a precharge to every bank
    assign bank_pre_target[g] = addr_in[`SDCBS_AP_BIT] || (bank_in == 2'(g));
    assign bank_timer_done[g] = (state_reg.bank_cnt[g] == sdcbs_count_t'(1));
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic banks_idle;
    logic in_burst;
    logic nop_like;
    logic run_banks;
    logic tick;
    logic auto_pre;
    logic busy;
    logic [11:0] packed_banks;
    logic cke_fall;
    logic cke_high;
    banks_idle = 1'b1;
    in_burst = 1'b0;
    nop_like = 1'b0;
    run_banks = 1'b0;
    tick = 1'b0;
    auto_pre = 1'b0;
    busy = 1'b0;
    packed_banks = 12'h000;
    cke_fall = 1'b0;
    cke_high = 1'b0;
    state_next = state_reg;
    state_next.cke_prev = cke_in; // [R1]
    // The action follows the pair of samples, never the present level alone
    cke_fall = state_reg.cke_prev && !cke_in; // [R1]
    cke_high = state_reg.cke_prev && cke_in; // [R1]
    banks_idle = &bank_idle;
    in_burst = |bank_burst;
    nop_like = (cmd == SDCBS_CMD_NOP) || (cmd == SDCBS_CMD_INHIBIT);
    auto_pre = addr_in[`SDCBS_AP_BIT];

    // Device-level clock-enable table, decided from both samples
    case (state_reg.dev)
      SDCBS_DEV_POWER_DOWN: begin
        // Both samples low: stay, whatever the command pins say [R2]
        if (cke_in) begin
          // Power-down exit; bank states were preserved, idle if they were
          state_next.dev = SDCBS_DEV_ACTIVE; // [R3] [R6]
        end
      end
      SDCBS_DEV_SELF_REFRESH: begin
        // Held while both samples are low [R2]
        if (cke_in) begin
          state_next.dev = SDCBS_DEV_SELF_EXIT; // [R7]
          state_next.dev_cnt = XSR_CYC;
        end
      end
      SDCBS_DEV_SELF_EXIT: begin
        // Commands are ignored until the exit time is over
        busy = 1'b1; // [R7] [R10]
        if (state_reg.dev_cnt <= sdcbs_count_t'(1)) begin
          state_next.dev = SDCBS_DEV_ACTIVE;
          state_next.dev_cnt = '0;
        end else begin
          state_next.dev_cnt = state_reg.dev_cnt - sdcbs_count_t'(1);
        end
      end
      SDCBS_DEV_SUSPEND: begin
        // Frozen while both samples are low [R2]; resumes, takes a command next edge
        if (cke_in) begin
          state_next.dev = SDCBS_DEV_ACTIVE; // [R5] [R9]
        end
      end
      SDCBS_DEV_REFRESHING, SDCBS_DEV_MODE_LOAD: begin
        busy = 1'b1; // [R23]
        if (state_reg.dev_cnt <= sdcbs_count_t'(1)) begin
          state_next.dev = SDCBS_DEV_ACTIVE;
          state_next.dev_cnt = '0;
        end else begin
          state_next.dev_cnt = state_reg.dev_cnt - sdcbs_count_t'(1);
        end
      end
      SDCBS_DEV_ACTIVE: begin
        if (cke_fall) begin
          // Suspend wins over power-down, so a burst in flight is kept
          if (in_burst) begin
            state_next.dev = SDCBS_DEV_SUSPEND; // [R5]
          end else if (banks_idle && cmd == SDCBS_CMD_REFRESH) begin
            state_next.dev = SDCBS_DEV_SELF_REFRESH; // [R4]
          end else if (nop_like) begin
            state_next.dev = SDCBS_DEV_POWER_DOWN; // [R3]
          end
        end else if (cke_high) begin
          run_banks = 1'b1; // [R10]
        end
      end
      default: begin
        // Unused code: fall back to active rather than lock up
        state_next.dev = SDCBS_DEV_ACTIVE;
        state_next.dev_cnt = '0;
      end
    endcase

    // Bank timers run on every edge outside suspend, power-down, self refresh and the suspend entry edge, so transients finish on time
    tick = !(state_reg.dev inside {SDCBS_DEV_SUSPEND, SDCBS_DEV_POWER_DOWN,
        SDCBS_DEV_SELF_REFRESH}) &&
        !(state_reg.dev == SDCBS_DEV_ACTIVE && cke_fall && in_burst); // [R5]
    for (int i = 0; i < `SDCBS_NUM_BANKS; i++) begin
      if (tick && state_reg.bank_cnt[i] != '0) begin
        state_next.bank_cnt[i] = state_reg.bank_cnt[i] - sdcbs_count_t'(1);
        if (bank_timer_done[i]) begin
          case (state_reg.bank[i])
            SDCBS_BANK_ACTIVATING: state_next.bank[i] = SDCBS_BANK_ROW_ACTIVE; // [R20]
            default: state_next.bank[i] = SDCBS_BANK_IDLE; // [R19] [R21]
          endcase
        end
      end
    end

    // One command a cycle; a refused one leaves no trace, save a terminate, which still clears burst_valid
    if (run_banks && !busy) begin
      case (cmd)
        SDCBS_CMD_REFRESH: begin
          if (banks_idle) begin
            state_next.dev = SDCBS_DEV_REFRESHING; // [R23] [R24]
            state_next.dev_cnt = REF_CYC;
          end
        end
        SDCBS_CMD_LOAD_MODE: begin
          if (banks_idle) begin
            state_next.dev = SDCBS_DEV_MODE_LOAD; // [R23] [R24]
            state_next.dev_cnt = MRD_CYC;
          end
        end
        SDCBS_CMD_ACTIVE: begin
          if (bank_idle[bank_in]) begin
            state_next.bank[bank_in] = SDCBS_BANK_ACTIVATING; // [R20]
            state_next.bank_cnt[bank_in] = ACT_CYC;
          end
        end
        SDCBS_CMD_READ, SDCBS_CMD_WRITE: begin
          if (bank_open[bank_in]) begin // [R13] [R14] [R15]
            if (cmd == SDCBS_CMD_READ) begin
              state_next.bank[bank_in] = auto_pre ? SDCBS_BANK_READ_AP :
                  SDCBS_BANK_READ; // [R17]
            end else begin
              state_next.bank[bank_in] = auto_pre ? SDCBS_BANK_WRITE_AP :
                  SDCBS_BANK_WRITE; // [R17]
            end
            // Burst length is not modelled: auto precharge ends after the period
            state_next.bank_cnt[bank_in] = auto_pre ? PRE_CYC : '0; // [R21]
            state_next.burst_valid = 1'b1;
            state_next.burst_bank = bank_in;
          end
        end
        SDCBS_CMD_TERMINATE: begin
          if (state_reg.burst_valid && bank_plain_burst[state_reg.burst_bank]) begin
            state_next.bank[state_reg.burst_bank] = SDCBS_BANK_ROW_ACTIVE; // [R16]
          end
          state_next.burst_valid = 1'b0;
        end
        SDCBS_CMD_PRECHARGE: begin
          for (int i = 0; i < `SDCBS_NUM_BANKS; i++) begin
            if (bank_pre_target[i] && bank_open[i]) begin
              // Idle banks are skipped, a precharge there is a no-op
              state_next.bank[i] = SDCBS_BANK_PRECHARGING; // [R14] [R15] [R19] [R26]
              state_next.bank_cnt[i] = PRE_CYC;
              if (state_reg.burst_bank == 2'(i)) begin
                state_next.burst_valid = 1'b0;
              end
            end
          end
        end
        default: begin
          // Inhibit and NOP let running operations continue
          state_next.burst_valid = state_reg.burst_valid; // [R11]
        end
      endcase
    end

    for (int i = 0; i < `SDCBS_NUM_BANKS; i++) begin
      packed_banks[3*i +: 3] = state_next.bank[i];
    end
    state_next.dev_out = state_next.dev;
    state_next.bank_out = packed_banks;
    state_next.all_idle = (packed_banks == 12'h000) &&
        (state_next.dev == SDCBS_DEV_ACTIVE);
    state_next.ready = (state_next.dev == SDCBS_DEV_ACTIVE); // [R6] [R9]
    state_next.suspend = (state_next.dev == SDCBS_DEV_SUSPEND);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset wins over enable_in, so a frozen block still clears
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_reg <= '0;
    end else if (enable_in) begin
      state_reg <= state_next;
    end
  end

  // Every port is a field of the state register, none is decoded on the way out
  assign dev_state_out = state_reg.dev_out;
  assign bank_state_out = state_reg.bank_out;
  assign all_idle_out = state_reg.all_idle;
  assign cmd_ready_out = state_reg.ready;
  assign burst_active_out = state_reg.burst_valid;
  assign burst_bank_out = state_reg.burst_bank;
  assign suspend_out = state_reg.suspend;

endmodule

/* src/sdcbs_decode.sv */
// Combinational decoder of the SDRAM command strobes into a command code.
// Assumes all strobes were sampled on the same rising edge.
`timescale 1ns/1ps

module sdcbs_decode
  import sdcbs_pkg::*;
(
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  output sdcbs_cmd_e cmd_out
);

  always_comb begin
    if (cs_n_in) begin
      cmd_out = SDCBS_CMD_INHIBIT; // [R11]
    end else begin
      case ({ras_n_in, cas_n_in, we_n_in})
        3'b111: cmd_out = SDCBS_CMD_NOP; // [R11]
        3'b011: cmd_out = SDCBS_CMD_ACTIVE; // [R12]
        3'b001: cmd_out = SDCBS_CMD_REFRESH; // [R12]
        3'b000: cmd_out = SDCBS_CMD_LOAD_MODE; // [R12]
        3'b010: cmd_out = SDCBS_CMD_PRECHARGE; // [R12]
        3'b101: cmd_out = SDCBS_CMD_READ; // [R13]
        3'b100: cmd_out = SDCBS_CMD_WRITE; // [R13]
        default: cmd_out = SDCBS_CMD_TERMINATE; // [R16]
      endcase
    end
  end

endmodule
